// ---- rtl/gesture_cfg_pkg.sv ----
// Package: register map, field layout, reset values and timing constants
package gesture_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] wait_cfg_addr_c      = 8'ha3;
  localparam logic [7:0] north_offset_addr_c  = 8'ha4;
  localparam logic [7:0] south_offset_addr_c  = 8'ha5;
  localparam logic [7:0] pulse_shape_addr_c   = 8'ha6;
  localparam logic [7:0] west_offset_addr_c   = 8'ha7;
  localparam logic [7:0] east_offset_addr_c   = 8'ha9;
  localparam logic [7:0] pair_select_addr_c   = 8'haa;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         width_lsb_c      = 6;
  localparam int         count_msb_c      = 5;
  localparam int         sign_bit_c       = 7;
  localparam logic [7:0] reg_reset_c      = 8'h00;
  localparam logic [2:0] idle_reset_c     = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int clk_mhz_c          = 40;
  localparam int clk_period_ps_c    = 25000;
  localparam int base_width_us_c    = 4;
  localparam int base_width_cyc_c   = base_width_us_c * clk_mhz_c;
  localparam int led_tail_ps_c      = 1330000;
  localparam int led_tail_cyc_c     = (led_tail_ps_c + clk_period_ps_c - 1) / clk_period_ps_c;
  localparam int pulse_gap_cyc_c    = 40;
  // Idle step 2.8 ms; codes are multiples of it
  localparam int idle_step_us_c     = 2800;
  localparam int idle_step_cyc_c    = idle_step_us_c * clk_mhz_c;

  // ----------------------------------------------------------------
  // Pair selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] pairs_ns_only_c = 2'h1;
  localparam logic [1:0] pairs_we_only_c = 2'h2;

  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_on    = 4'b0010,
    st_gap   = 4'b0100,
    st_wait  = 4'b1000
  } pulse_state_type;

  // Idle multiplier per wait code: 0,1,2,3,5,8,11,14 steps
  function automatic logic [3:0] idle_steps(input logic [2:0] code);
    logic [3:0] s;
    s = 4'h0;
    unique case (code)
      3'h0: s = 4'h0;
      3'h1: s = 4'h1;
      3'h2: s = 4'h2;
      3'h3: s = 4'h3;
      3'h4: s = 4'h5;
      3'h5: s = 4'h8;
      3'h6: s = 4'hb;
      3'h7: s = 4'he;
    endcase
    return s;
  endfunction

endpackage

// ---- rtl/offset_decode.sv ----
// Sign/magnitude offset byte to two's complement correction
`timescale 1ns/1ps
`default_nettype none
module offset_decode (
  input  wire logic [7:0] code,
  output logic      [8:0] correction
);
  import gesture_cfg_pkg::*;

  always_comb begin
    // Negative zero folds to zero
    if (code[sign_bit_c] && code[6:0] != 7'h00) begin
      correction = 9'h000 - {2'h0, code[6:0]};
    end else begin
      correction = {2'h0, code[6:0]};
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pulse_width_lut.sv ----
// LED-on width select to cycle count
`timescale 1ns/1ps
`default_nettype none
module pulse_width_lut (
  input  wire logic [1:0]  width_sel,
  output logic      [12:0] on_cycles
);
  import gesture_cfg_pkg::*;

  localparam logic [12:0] base_c = 13'(base_width_cyc_c);
  localparam logic [12:0] tail_c = 13'(led_tail_cyc_c);

  // Integration window is 4/8/16/32 us; LED stays on for the tail beyond it
  always_comb begin
    on_cycles = (base_c << width_sel) + tail_c;
  end
endmodule
`default_nettype wire

// ---- rtl/gesture_pulse_offset_config.sv ----
// Gesture configuration registers and LED pulse burst sequencer
//
// Overview of operation
// - The LED stays on about 1.33 us longer than the integration window.
// - Each of the four direction channels has its own 8-bit crosstalk offset.
// - Offset bytes are sign/magnitude: bit 7 negative, bits 6:0 magnitude.
// - Width code 0..3 picks a 4, 8, 16 or 32 us integration window per pulse.
// - Each burst has the six-bit count field plus one pulses on the LED sink.
// - Pair code 1 runs north-south only, 2 west-east only, 0 and 3 both.
// - With one pair off, the pulse timing and sample rate stay the same.
// - Between cycles the engine idles for a time set by a three-bit code.
`timescale 1ns/1ps
`default_nettype none
module gesture_pulse_offset_config #(
  parameter int idle_step_cycles = gesture_cfg_pkg::idle_step_cyc_c
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       gesture_engine_on,
  output logic            led_sink_pin,
  output logic            ns_pair_active,
  output logic            we_pair_active,
  output logic            sample_strobe,
  output logic            cycle_active,
  output logic      [8:0] north_correction,
  output logic      [8:0] south_correction,
  output logic      [8:0] west_correction,
  output logic      [8:0] east_correction
);
  import gesture_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      north_r;
    logic [7:0]      south_r;
    logic [7:0]      west_r;
    logic [7:0]      east_r;
    logic [7:0]      shape_r;
    logic [1:0]      pairs_r;
    logic [2:0]      idle_r;
    logic [7:0]      rdata_r;
    pulse_state_type st_r;
    logic [12:0]     cnt_r;
    logic [5:0]      pulses_r;
    logic [3:0]      steps_r;
    logic [31:0]     idle_cnt_r;
    logic            led_r;
    logic            strobe_r;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic [12:0] on_cycles;
  logic        ns_on;
  logic        we_on;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  pulse_width_lut u_width (
    .width_sel (s_r.shape_r[7:width_lsb_c]),
    .on_cycles (on_cycles)
  );

  offset_decode u_north (.code(s_r.north_r), .correction(north_correction));
  offset_decode u_south (.code(s_r.south_r), .correction(south_correction));
  offset_decode u_west  (.code(s_r.west_r),  .correction(west_correction));
  offset_decode u_east  (.code(s_r.east_r),  .correction(east_correction));

  // Pair enables; software still sees FIFO slots for an off pair
  always_comb begin
    ns_on = (s_r.pairs_r != pairs_we_only_c);
    we_on = (s_r.pairs_r != pairs_ns_only_c);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.strobe_r = 1'b0;

    // Register writes; offset and shape store all 8 bits, wait and pair codes only their low bits
    if (reg_wr) begin
      unique case (reg_addr)
        wait_cfg_addr_c:     s_nxt.idle_r  = reg_wdata[2:0];
        north_offset_addr_c: s_nxt.north_r = reg_wdata;
        south_offset_addr_c: s_nxt.south_r = reg_wdata;
        pulse_shape_addr_c:  s_nxt.shape_r = reg_wdata;
        west_offset_addr_c:  s_nxt.west_r  = reg_wdata;
        east_offset_addr_c:  s_nxt.east_r  = reg_wdata;
        // Upper bits are dropped; software is expected to write them zero
        pair_select_addr_c:  s_nxt.pairs_r = reg_wdata[1:0];
        default: ;
      endcase
    end

    // Registered read data, unmapped reads as zero
    if (reg_rd) begin
      unique case (reg_addr)
        wait_cfg_addr_c:     s_nxt.rdata_r = {5'h00, s_r.idle_r};
        north_offset_addr_c: s_nxt.rdata_r = s_r.north_r;
        south_offset_addr_c: s_nxt.rdata_r = s_r.south_r;
        pulse_shape_addr_c:  s_nxt.rdata_r = s_r.shape_r;
        west_offset_addr_c:  s_nxt.rdata_r = s_r.west_r;
        east_offset_addr_c:  s_nxt.rdata_r = s_r.east_r;
        pair_select_addr_c:  s_nxt.rdata_r = {6'h00, s_r.pairs_r};
        default:             s_nxt.rdata_r = 8'h00;
      endcase
    end

    // Burst sequencer
    unique case (s_r.st_r)
      st_idle: begin
        s_nxt.led_r = 1'b0;
        if (gesture_engine_on) begin
          s_nxt.st_r     = st_on;
          s_nxt.led_r    = 1'b1;
          s_nxt.cnt_r    = on_cycles - 13'h1;
          s_nxt.pulses_r = s_r.shape_r[count_msb_c:0];
        end
      end
      st_on: begin
        if (s_r.cnt_r == 13'h0) begin
          s_nxt.led_r    = 1'b0;
          s_nxt.strobe_r = 1'b1;
          s_nxt.st_r     = st_gap;
          // Fixed gap of pulse_gap_cyc_c cycles, the same with one pair or both
          s_nxt.cnt_r    = 13'(pulse_gap_cyc_c - 1);
        end else begin
          s_nxt.cnt_r = s_r.cnt_r - 13'h1;
        end
      end
      st_gap: begin
        if (s_r.cnt_r != 13'h0) begin
          s_nxt.cnt_r = s_r.cnt_r - 13'h1;
        end else if (s_r.pulses_r != 6'h0) begin
          s_nxt.pulses_r = s_r.pulses_r - 6'h1;
          s_nxt.st_r     = st_on;
          s_nxt.led_r    = 1'b1;
          s_nxt.cnt_r    = on_cycles - 13'h1;
        end else begin
          s_nxt.st_r       = st_wait;
          s_nxt.steps_r    = idle_steps(s_r.idle_r);
          s_nxt.idle_cnt_r = 32'h0;
        end
      end
      st_wait: begin
        // Idle code is sampled at burst end; change it while off
        if (s_r.steps_r == 4'h0) begin
          s_nxt.st_r = st_idle;
        end else if (s_r.idle_cnt_r == 32'(idle_step_cycles - 1)) begin
          s_nxt.idle_cnt_r = 32'h0;
          s_nxt.steps_r    = s_r.steps_r - 4'h1;
        end else begin
          s_nxt.idle_cnt_r = s_r.idle_cnt_r + 32'h1;
        end
      end
      default: s_nxt.st_r = st_idle;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{north_r: reg_reset_c, south_r: reg_reset_c, west_r: reg_reset_c,
               east_r: reg_reset_c, shape_r: reg_reset_c, pairs_r: 2'h0,
               idle_r: idle_reset_c, rdata_r: 8'h00, st_r: st_idle,
               cnt_r: 13'h0, pulses_r: 6'h0, steps_r: 4'h0,
               idle_cnt_r: 32'h0, led_r: 1'b0, strobe_r: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata      = s_r.rdata_r;
  assign led_sink_pin   = s_r.led_r;
  assign sample_strobe  = s_r.strobe_r;
  assign ns_pair_active = ns_on;
  assign we_pair_active = we_on;
  assign cycle_active   = (s_r.st_r == st_on) || (s_r.st_r == st_gap);

endmodule
`default_nettype wire

// ---- dv/gesture_cfg_asserts.sv ----
// Checker: port-level assertions for the gesture configuration block
`timescale 1ns/1ps
`default_nettype none
module gesture_cfg_asserts #(parameter int idle_step_cycles = 10) (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       gesture_engine_on,
  input wire logic       led_sink_pin,
  input wire logic       ns_pair_active,
  input wire logic       we_pair_active,
  input wire logic       sample_strobe,
  input wire logic       cycle_active,
  input wire logic [8:0] north_correction,
  input wire logic [8:0] south_correction,
  input wire logic [8:0] west_correction,
  input wire logic [8:0] east_correction
);
  logic [7:0]  shape_r;
  logic [13:0] on_r;
  logic [6:0]  seen_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  function automatic logic [8:0] sm(input logic [7:0] b);
    return b[7] ? 9'h000 - 9'(b[6:0]) : 9'(b[6:0]);
  endfunction
  // ----
  // Mirrors; the shape mirror is only valid if shape is rewritten between bursts
  // ----
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shape_r <= 8'h00;
      on_r    <= 14'h0000;
      seen_r  <= 7'h00;
    end else begin
      shape_r <= (reg_wr && reg_addr == 8'ha6) ? reg_wdata : shape_r;
      on_r    <= led_sink_pin ? on_r + 14'h0001 : 14'h0000;
      seen_r  <= cycle_active ? seen_r + {6'h00, sample_strobe} : 7'h00;
    end
  end
  a_north_offset: assert property (reg_wr && reg_addr == 8'ha4 |=>
    north_correction == sm($past(reg_wdata))) else $error("north offset");
  a_south_offset: assert property (reg_wr && reg_addr == 8'ha5 |=>
    south_correction == sm($past(reg_wdata))) else $error("south offset");
  a_west_offset: assert property (reg_wr && reg_addr == 8'ha7 |=>
    west_correction == sm($past(reg_wdata))) else $error("west offset");
  a_east_offset: assert property (reg_wr && reg_addr == 8'ha9 |=>
    east_correction == sm($past(reg_wdata))) else $error("east offset");
  a_pair_enables: assert property (reg_wr && reg_addr == 8'haa |=>
    ns_pair_active == ($past(reg_wdata[1:0]) != 2'h2) &&
    we_pair_active == ($past(reg_wdata[1:0]) != 2'h1)) else $error("pair enables");
  a_led_width: assert property ($fell(led_sink_pin) |->
    on_r == (14'h00a0 << shape_r[7:6]) + 14'h0036) else $error("led width");
  a_burst_count: assert property ($fell(cycle_active) |->
    seen_r + {6'h00, sample_strobe} == {1'b0, shape_r[5:0]} + 7'h01) else $error("pulse count");
  a_unmapped_read: assert property (reg_rd && !(reg_addr inside {8'ha3, 8'ha4, 8'ha5,
    8'ha6, 8'ha7, 8'ha9, 8'haa}) |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule
bind gesture_pulse_offset_config gesture_cfg_asserts #(.idle_step_cycles(idle_step_cycles))
  u_chk (.clk_sys,
  .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .gesture_engine_on,
  .led_sink_pin, .ns_pair_active, .we_pair_active, .sample_strobe, .cycle_active,
  .north_correction, .south_correction, .west_correction, .east_correction);
`default_nettype wire

// ---- dv/gesture_host.sv ----
// Host model: register bus master for the gesture configuration block
`timescale 1ns/1ps
`default_nettype none
module gesture_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output var logic        reg_wr,
  output var logic        reg_rd,
  output var logic  [7:0] reg_addr,
  output var logic  [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    repeat (1 + $urandom % 3) @(posedge clk_sys);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = (a == 8'haa) ? (d & 8'h03) : d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Testbench: registers, offsets, pair select and LED bursts
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gesture_cfg_pkg::*;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       gesture_engine_on = 1'b0;
  logic       pl = 1'b0;
  logic       reg_wr, reg_rd, led_sink_pin, ns_pair_active, we_pair_active;
  logic       sample_strobe, cycle_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, v;
  logic [5:0] cnt;
  logic [8:0] corr [4];
  int         num_errors = 0;
  int         cmp_count = 0;
  int         n, w, t, e, sc;
  logic [7:0] regs [8] = '{8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9, 8'haa, 8'ha8};
  logic [7:0] dirs [4] = '{8'ha4, 8'ha5, 8'ha7, 8'ha9};
  logic [7:0] hard [5] = '{8'h7f, 8'h00, 8'h80, 8'h81, 8'hff};
  int         steps [8] = '{0, 1, 2, 3, 5, 8, 11, 14};
  always #12.5 clk_sys = ~clk_sys;
  gesture_host host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  gesture_pulse_offset_config #(.idle_step_cycles(10)) dut (.clk_sys, .resetn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .gesture_engine_on, .led_sink_pin, .ns_pair_active,
    .we_pair_active, .sample_strobe, .cycle_active, .north_correction(corr[0]),
    .south_correction(corr[1]), .west_correction(corr[2]), .east_correction(corr[3]));
  function automatic logic [8:0] sm(input logic [7:0] b);
    return b[7] ? 9'h000 - 9'(b[6:0]) : 9'(b[6:0]);
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts pulses and the latest pulse width while waiting for cycle_active
  task automatic track(input logic lvl);
    t = 0;
    while (cycle_active !== lvl && t < 30000) begin
      @(posedge clk_sys);
      #1;
      n += int'(led_sink_pin && !pl);
      sc += int'(sample_strobe === 1'b1);
      w = (led_sink_pin && !pl) ? 1 : w + int'(led_sink_pin);
      pl = led_sink_pin;
      t++;
    end
    // A burst that never settles counts against the run
    if (t >= 30000) begin
      num_errors++;
      $display("MISMATCH %0t burst tracking timed out", $time);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h3057));
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b1;
    foreach (regs[i]) begin
      host.xfer(1'b0, regs[i], 8'h00, rv);
      cmp(16'(rv), 16'h0000);
    end
    host.xfer(1'b1, 8'ha8, 8'h5a, rv);
    host.xfer(1'b0, 8'ha8, 8'h00, rv);
    cmp(16'(rv), 16'h0000);
    $display("test registers done");
    foreach (dirs[d]) begin
      for (int k = 0; k < 8; k++) begin
        v = (k < 5) ? hard[k] : 8'($urandom);
        host.xfer(1'b1, dirs[d], v, rv);
        cmp(16'(corr[d]), 16'(sm(v)));
        host.xfer(1'b0, dirs[d], 8'h00, rv);
        cmp(16'(rv), 16'(v));
      end
    end
    $display("test offsets done");
    for (int c = 0; c < 4; c++) begin
      host.xfer(1'b1, pair_select_addr_c, {6'($urandom), 2'(c)}, rv);
      cmp(16'({ns_pair_active, we_pair_active}), 16'({c != 2, c != 1}));
      host.xfer(1'b0, pair_select_addr_c, 8'h00, rv);
      cmp(16'(rv), 16'(c));
    end
    $display("test pairs done");
    for (int s = 0; s < 4; s++) begin
      cnt = (s == 0) ? 6'h3f : 6'($urandom % 2);
      e = steps[2 * s + 1] * 10;
      host.xfer(1'b1, wait_cfg_addr_c, 8'(2 * s + 1), rv);
      host.xfer(1'b1, pulse_shape_addr_c, {2'(s), cnt}, rv);
      n = 0;
      sc = 0;
      gesture_engine_on = 1'b1;
      track(1'b1);
      track(1'b0);
      cmp(16'(n), 16'(cnt) + 16'h0001);
      cmp(16'(sc), 16'(cnt) + 16'h0001);
      cmp(16'(w), 16'((160 << s) + 54));
      n = 0;
      sc = 0;
      track(1'b1);
      cmp(16'(t >= e && t <= e + 3), 16'h0001);
      gesture_engine_on = 1'b0;
      track(1'b0);
      cmp(16'(n), 16'(cnt) + 16'h0001);
      cmp(16'(sc), 16'(cnt) + 16'h0001);
      repeat (e + 20) @(posedge clk_sys);
      #1;
      cmp(16'(cycle_active), 16'h0000);
    end
    $display("test bursts done");
    report_and_stop();
  end
endmodule
`default_nettype wire
